// *** memmap_pkg.sv ***
// Purpose: Constants and types shared by the memory map decoder.
// Assumes: 16-bit CPU addresses, 8-bit data, one clock domain.
// Notes:   Overview list follows.
//
// Overview of operation
// - One 64 KB space, four regions decoded
// - 0x0000-0x007F selects peripheral I/O registers
// - 0x0F80-0x0FFF selects extended I/O registers
// - Direct 0x0090-0x00FF reaches RAM unbanked at bank zero
// - Banked addresses past variant RAM limit raise bank_oob_o
// - 0x0100-0x01FF is register area and RAM
// - 0xFFC0-0xFFFF flash vector table region
// - 0xFFBB-0xFFBF reserved nonvolatile setting store
// - Three-bit bank pointer resets to zero
// - Direct 0x0000-0x007F always reaches I/O
// - Bank n maps to 0x0080 plus n*0x80
// - Port data and direction registers reset zero
// - Oscillator wait select resets to all ones
// - Clock control low five bits reset 11011
package memmap_pkg;

  // Region limits
  localparam logic [15:0] IO_LO      = 16'h0000;
  localparam logic [15:0] IO_HI      = 16'h007F;
  localparam logic [15:0] XIO_LO     = 16'h0F80;
  localparam logic [15:0] XIO_HI     = 16'h0FFF;
  localparam logic [15:0] DIR_RAM_LO = 16'h0090;
  localparam logic [15:0] DIR_RAM_HI = 16'h00FF;
  localparam logic [15:0] GPR_LO     = 16'h0100;
  localparam logic [15:0] GPR_HI     = 16'h01FF;
  localparam logic [15:0] BANK_TOP_L = 16'h047F;
  localparam logic [15:0] BANK_TOP_S = 16'h028F;
  localparam logic [15:0] NVS_LO     = 16'hFFBB;
  localparam logic [15:0] NVS_HI     = 16'hFFBF;
  localparam logic [15:0] VEC_LO     = 16'hFFC0;
  localparam logic [15:0] VEC_HI     = 16'hFFFF;
  localparam logic [15:0] FLASH_LO   = 16'h1000;
  localparam logic [7:0]  BANK_STEP  = 8'h80;

  // Register offsets
  localparam logic [6:0] OFS_P0_DATA = 7'h00;
  localparam logic [6:0] OFS_P0_DIR  = 7'h01;
  localparam logic [6:0] OFS_P1_DATA = 7'h02;
  localparam logic [6:0] OFS_P1_DIR  = 7'h03;
  localparam logic [6:0] OFS_WAIT    = 7'h05;
  localparam logic [6:0] OFS_PLL     = 7'h06;
  localparam logic [6:0] OFS_SYSCLK  = 7'h07;
  localparam logic [6:0] OFS_STBY    = 7'h08;
  localparam logic [6:0] OFS_RSTREC  = 7'h09;
  localparam logic [6:0] OFS_TBT     = 7'h0A;
  localparam logic [6:0] OFS_WPRE    = 7'h0B;
  localparam logic [6:0] OFS_WDOG    = 7'h0C;
  localparam logic [6:0] OFS_SYSCLK2 = 7'h0D;
  localparam logic [6:0] OFS_STBY2   = 7'h0E;
  localparam logic [6:0] OFS_P4_DATA = 7'h12;
  localparam logic [6:0] OFS_P4_DIR  = 7'h13;
  localparam logic [6:0] OFS_P6_DATA = 7'h16;
  localparam logic [6:0] OFS_P6_DIR  = 7'h17;
  localparam logic [6:0] OFS_P7_DATA = 7'h18;
  localparam logic [6:0] OFS_P7_DIR  = 7'h19;
  localparam logic [6:0] OFS_PF_DATA = 7'h28;
  localparam logic [6:0] OFS_PF_DIR  = 7'h29;
  localparam logic [6:0] OFS_PG_DATA = 7'h2A;
  localparam logic [6:0] OFS_PG_DIR  = 7'h2B;
  localparam logic [6:0] OFS_PU0     = 7'h2C;
  localparam logic [6:0] OFS_PU1     = 7'h2D;

  // Reset values
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_WAIT    = 8'hFF;
  localparam logic [7:0] RST_SYSCLK  = 8'h1B;
  localparam logic [7:0] RST_SYSCLK2 = 8'h03;
  localparam logic [2:0] RST_BANK    = 3'h0;

  // One-hot target select
  typedef struct packed {
    logic io;
    logic xio;
    logic ram;
    logic flash;
  } target_sel_t;

  // Flash sub-area flags
  typedef struct packed {
    logic vector;
    logic nv_store;
  } flash_area_t;

  // CPU access request
  typedef struct packed {
    logic [15:0] addr;
    logic        direct;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } cpu_req_t;

endpackage : memmap_pkg

// *** bank_mapper.sv ***
// Purpose: Turn a direct-addressing operand into a physical address.
// Assumes: Operand is the low byte of a direct instruction.
// Notes:   Pure combinational map.
`timescale 1ns/1ns
module bank_mapper (
  // Operand and bank pointer
  input  wire logic [7:0]  operand_i,
  input  wire logic [2:0]  bank_i,
  // Physical address
  output logic      [15:0] phys_o
);
  import memmap_pkg::*;

  // Low half of operand space is fixed, upper half is banked
  always_comb begin
    if (!operand_i[7] || bank_i == RST_BANK) begin
      phys_o = {8'h00, operand_i};
    end else begin
      // Window base = 0x0080 + bank * 0x80
      phys_o = {6'h00, bank_i, 7'h00} + {8'h00, operand_i};
    end
  end

endmodule : bank_mapper

// *** memory_map_decoder.sv ***
// Purpose: Steer CPU accesses to I/O, extended I/O, RAM and flash.
// Assumes: Registers capture on the clock edge of a write request.
// Notes:   Selects are registered one cycle after the request.
`timescale 1ns/1ns
module memory_map_decoder #(
  parameter logic SMALL_RAM = 1'b0 // 1 selects the smaller RAM variant
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    arst_n_i,
  // CPU access
  input  wire memmap_pkg::cpu_req_t    req_i,
  // Target selection
  output memmap_pkg::target_sel_t      sel_o,
  output memmap_pkg::flash_area_t      flash_area_o,
  output logic                         gpr_area_o,
  output logic                         bank_oob_o,
  output logic [15:0]                  phys_addr_o,
  // Register read path
  output logic [7:0]                   rdata_o,
  output logic                         rvalid_o,
  // Bank pointer
  input  wire logic                    bank_wr_i,
  input  wire logic [2:0]              bank_wdata_i,
  output logic [2:0]                   bank_o,
  // Control register outputs
  output logic [7:0]                   osc_wait_o,
  output logic [7:0]                   sysclk_ctrl_o,
  output logic [7:0]                   standby_ctrl_o
);
  import memmap_pkg::*;

  localparam int NREG = 26;

  // Register storage and offsets
  logic [7:0]  regs [NREG];        // Register file
  logic [6:0]  reg_ofs [NREG];     // Offset per entry
  logic [7:0]  reg_rst [NREG];     // Reset value per entry
  logic [NREG-1:0] hit;            // Offset match per entry
  logic        any_hit;            // Offset is assigned
  logic [15:0] mapped;             // Direct-operand translation
  logic [15:0] paddr;              // Physical address
  target_sel_t next_sel;           // Decoded select
  logic [7:0]  hit_data;           // Read mux result
  logic [2:0]  bank;               // Direct bank pointer
  logic [15:0] bank_top;           // Usable top of banked area

  // Offset and reset tables
  always_comb begin
    reg_ofs[0]  = OFS_P0_DATA;  reg_rst[0]  = RST_ZERO;
    reg_ofs[1]  = OFS_P0_DIR;   reg_rst[1]  = RST_ZERO;
    reg_ofs[2]  = OFS_P1_DATA;  reg_rst[2]  = RST_ZERO;
    reg_ofs[3]  = OFS_P1_DIR;   reg_rst[3]  = RST_ZERO;
    reg_ofs[4]  = OFS_WAIT;     reg_rst[4]  = RST_WAIT;
    reg_ofs[5]  = OFS_PLL;      reg_rst[5]  = RST_ZERO;
    reg_ofs[6]  = OFS_SYSCLK;   reg_rst[6]  = RST_SYSCLK;
    reg_ofs[7]  = OFS_STBY;     reg_rst[7]  = RST_ZERO;
    reg_ofs[8]  = OFS_RSTREC;   reg_rst[8]  = RST_ZERO;
    reg_ofs[9]  = OFS_TBT;      reg_rst[9]  = RST_ZERO;
    reg_ofs[10] = OFS_WPRE;     reg_rst[10] = RST_ZERO;
    reg_ofs[11] = OFS_WDOG;     reg_rst[11] = RST_ZERO;
    reg_ofs[12] = OFS_SYSCLK2;  reg_rst[12] = RST_SYSCLK2;
    reg_ofs[13] = OFS_STBY2;    reg_rst[13] = RST_ZERO;
    reg_ofs[14] = OFS_P4_DATA;  reg_rst[14] = RST_ZERO;
    reg_ofs[15] = OFS_P4_DIR;   reg_rst[15] = RST_ZERO;
    reg_ofs[16] = OFS_P6_DATA;  reg_rst[16] = RST_ZERO;
    reg_ofs[17] = OFS_P6_DIR;   reg_rst[17] = RST_ZERO;
    reg_ofs[18] = OFS_P7_DATA;  reg_rst[18] = RST_ZERO;
    reg_ofs[19] = OFS_P7_DIR;   reg_rst[19] = RST_ZERO;
    reg_ofs[20] = OFS_PF_DATA;  reg_rst[20] = RST_ZERO;
    reg_ofs[21] = OFS_PF_DIR;   reg_rst[21] = RST_ZERO;
    reg_ofs[22] = OFS_PG_DATA;  reg_rst[22] = RST_ZERO;
    reg_ofs[23] = OFS_PG_DIR;   reg_rst[23] = RST_ZERO;
    reg_ofs[24] = OFS_PU0;      reg_rst[24] = RST_ZERO;
    reg_ofs[25] = OFS_PU1;      reg_rst[25] = RST_ZERO;
  end

  // Direct operands go through the bank window
  bank_mapper u_map (
    .operand_i (req_i.addr[7:0]),
    .bank_i    (bank),
    .phys_o    (mapped)
  );

  // Physical address: direct operand translated, else as given
  assign paddr = req_i.direct ? mapped : req_i.addr;
  assign bank_top = SMALL_RAM ? BANK_TOP_S : BANK_TOP_L;

  // Region decode, one-hot by construction
  always_comb begin
    next_sel = '0;
    if (paddr <= IO_HI) begin
      next_sel.io = 1'b1;
    end else if (paddr >= XIO_LO && paddr <= XIO_HI) begin
      next_sel.xio = 1'b1;
    end else if (paddr < FLASH_LO) begin
      next_sel.ram = 1'b1;
    end else begin
      next_sel.flash = 1'b1;
    end
  end

  // Register hit per entry
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_hit
      assign hit[g] = next_sel.io && (paddr[6:0] == reg_ofs[g]);
    end
  endgenerate
  assign any_hit = |hit;

  // Read mux, unassigned offsets return zero
  always_comb begin
    hit_data = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (hit[i]) begin
        hit_data = regs[i];
      end
    end
  end

  // Register file writes; unassigned offsets drop the write
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < NREG; i++) begin
        regs[i] <= 8'h00;
      end
      regs[4]  <= RST_WAIT;
      regs[6]  <= RST_SYSCLK;
      regs[12] <= RST_SYSCLK2;
    end else begin
      for (int i = 0; i < NREG; i++) begin
        if (req_i.wr && hit[i]) begin
          regs[i] <= req_i.wdata;
        end
      end
    end
  end

  // Direct bank pointer
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bank <= RST_BANK;
    end else if (bank_wr_i) begin
      bank <= bank_wdata_i;
    end
  end

  // Registered selects and address
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_o        <= '0;
      flash_area_o <= '0;
      gpr_area_o   <= 1'b0;
      bank_oob_o   <= 1'b0;
      phys_addr_o  <= 16'h0000;
    end else begin
      sel_o                 <= next_sel;
      flash_area_o.vector   <= paddr >= VEC_LO;
      flash_area_o.nv_store <= paddr >= NVS_LO && paddr <= NVS_HI;
      gpr_area_o            <= paddr >= GPR_LO && paddr <= GPR_HI;
      bank_oob_o  <= req_i.direct && paddr > bank_top
                     && paddr < FLASH_LO;
      phys_addr_o <= paddr;
    end
  end

  // Register read data
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rdata_o  <= hit_data;
      rvalid_o <= req_i.rd && any_hit;
    end
  end

  // Mirror selected control registers to outputs
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bank_o         <= RST_BANK;
      osc_wait_o     <= RST_WAIT;
      sysclk_ctrl_o  <= RST_SYSCLK;
      standby_ctrl_o <= RST_ZERO;
    end else begin
      bank_o         <= bank;
      osc_wait_o     <= regs[4];
      sysclk_ctrl_o  <= regs[6];
      standby_ctrl_o <= regs[7];
    end
  end

  // One select per registered access
  property p_one_hot;
    @(posedge clk_i) disable iff (!arst_n_i)
      arst_n_i |=> $onehot(sel_o);
  endproperty
  a_one_hot: assert property (p_one_hot)
    else $error("target select not one-hot");

  // Low direct operands land in I/O
  property p_direct_io;
    @(posedge clk_i) disable iff (!arst_n_i)
      (arst_n_i && req_i.direct && !req_i.addr[7]) |=> sel_o.io;
  endproperty
  a_direct_io: assert property (p_direct_io)
    else $error("low direct operand missed I/O");

  // Bank pointer reset value
  property p_bank_rst;
    @(posedge clk_i) $rose(arst_n_i) |-> bank == RST_BANK;
  endproperty
  a_bank_rst: assert property (p_bank_rst)
    else $error("bank pointer not zero after reset");

  // Unassigned I/O read gives no valid
  property p_unassigned;
    @(posedge clk_i) disable iff (!arst_n_i)
      (req_i.rd && next_sel.io && !any_hit) |=> !rvalid_o;
  endproperty
  a_unassigned: assert property (p_unassigned)
    else $error("unassigned read answered");

  // Extended I/O range
  property p_xio;
    @(posedge clk_i) disable iff (!arst_n_i)
      (paddr >= XIO_LO && paddr <= XIO_HI) |=> sel_o.xio;
  endproperty
  a_xio: assert property (p_xio)
    else $error("extended I/O not selected");

  // Vector area in flash
  property p_vec;
    @(posedge clk_i) disable iff (!arst_n_i)
      (paddr >= VEC_LO) |=> (flash_area_o.vector && sel_o.flash);
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector area not flagged");

  // Port 0 data write is held in its entry the next cycle
  property p_port_wr;
    @(posedge clk_i) disable iff (!arst_n_i)
      (req_i.wr && hit[0]) |=> regs[0] == $past(req_i.wdata);
  endproperty
  a_port_wr: assert property (p_port_wr)
    else $error("port data latch not written");

  // Banked window start
  property p_bank_win;
    @(posedge clk_i) disable iff (!arst_n_i)
      (req_i.direct && bank == 3'h1 && req_i.addr[7:0] == 8'h80)
        |=> phys_addr_o == GPR_LO;
  endproperty
  a_bank_win: assert property (p_bank_win)
    else $error("bank one window misplaced");

  // Per-entry checks on the register file
  generate
    for (g = 0; g < NREG; g++) begin : g_chk
      // Every entry starts from its own reset value
      property p_rst_val;
        @(posedge clk_i) $rose(arst_n_i) |-> regs[g] == reg_rst[g];
      endproperty
      a_rst_val: assert property (p_rst_val)
        else $error("register entry missed its reset value");

      // An entry changes only when its own offset is written
      property p_hold;
        @(posedge clk_i) disable iff (!arst_n_i)
          (arst_n_i && !(req_i.wr && hit[g])) |=> regs[g] == $past(regs[g]);
      endproperty
      a_hold: assert property (p_hold)
        else $error("register entry changed without a write");
    end
  endgenerate

  // Write request to the wait select entry
  sequence s_wait_wr;
    arst_n_i && req_i.wr && hit[4];
  endsequence

  // Write request to the clock control entry
  sequence s_sysclk_wr;
    arst_n_i && req_i.wr && hit[6];
  endsequence

  // Written wait select reaches its output two edges later
  property p_wait_mirror;
    @(posedge clk_i) disable iff (!arst_n_i)
      s_wait_wr |=> ##1 osc_wait_o == $past(req_i.wdata, 2);
  endproperty
  a_wait_mirror: assert property (p_wait_mirror)
    else $error("wait select output lost a write");

  // Written clock control reaches its output two edges later
  property p_sysclk_mirror;
    @(posedge clk_i) disable iff (!arst_n_i)
      s_sysclk_wr |=> ##1 sysclk_ctrl_o == $past(req_i.wdata, 2);
  endproperty
  a_sysclk_mirror: assert property (p_sysclk_mirror)
    else $error("clock control output lost a write");

  // Control outputs leave reset at their reset values
  property p_mirror_rst;
    @(posedge clk_i) $rose(arst_n_i) |->
      osc_wait_o == RST_WAIT && sysclk_ctrl_o == RST_SYSCLK
      && bank_o == RST_BANK;
  endproperty
  a_mirror_rst: assert property (p_mirror_rst)
    else $error("control output wrong after reset");

  // Direct operand in the upper half with a nonzero bank
  sequence s_banked_op;
    arst_n_i && req_i.direct && req_i.addr[7] && bank != RST_BANK;
  endsequence

  // Direct RAM operand with the bank pointer at its reset value
  sequence s_plain_op;
    arst_n_i && req_i.direct && bank == RST_BANK
    && req_i.addr[7:0] >= DIR_RAM_LO[7:0];
  endsequence

  // Bank zero leaves direct RAM operands untranslated
  property p_bank0;
    @(posedge clk_i) disable iff (!arst_n_i)
      s_plain_op |=> sel_o.ram
        && phys_addr_o == {8'h00, $past(req_i.addr[7:0])};
  endproperty
  a_bank0: assert property (p_bank0)
    else $error("bank zero moved a direct operand");

  // Banked operands stay in the window and keep their low bits
  property p_bank_range;
    @(posedge clk_i) disable iff (!arst_n_i)
      s_banked_op |=> phys_addr_o >= GPR_LO && phys_addr_o <= BANK_TOP_L
        && phys_addr_o[6:0] == $past(req_i.addr[6:0]);
  endproperty
  a_bank_range: assert property (p_bank_range)
    else $error("banked operand outside its window");

  // Register area is flagged and stays in RAM
  property p_gpr;
    @(posedge clk_i) disable iff (!arst_n_i)
      (arst_n_i && paddr >= GPR_LO && paddr <= GPR_HI)
        |=> gpr_area_o && sel_o.ram;
  endproperty
  a_gpr: assert property (p_gpr)
    else $error("register area not flagged");

  // Setting store sits in flash just below the vectors
  property p_nv;
    @(posedge clk_i) disable iff (!arst_n_i)
      (arst_n_i && paddr >= NVS_LO && paddr <= NVS_HI)
        |=> flash_area_o.nv_store && sel_o.flash && !flash_area_o.vector;
  endproperty
  a_nv: assert property (p_nv)
    else $error("setting store area not flagged");

endmodule : memory_map_decoder

// *** cpu_model.sv ***
// Purpose: CPU core model that issues decoder requests.
// Assumes: Requests change just after a rising edge.
// Notes:   Released requests drop strobes and show inverted address and data.
`timescale 1ns/1ns
module cpu_model (
  // Clock
  input  wire logic           clk_i,
  // Request to the decoder
  output memmap_pkg::cpu_req_t req_o,
  // Bank pointer write
  output logic                bank_wr_o,
  output logic [2:0]          bank_wdata_o
);
  import memmap_pkg::*;

  // Quiet bus at time zero
  initial begin
    req_o        = '0;
    bank_wr_o    = 1'b0;
    bank_wdata_o = 3'h0;
  end

  // One access held for one edge, then released
  task automatic access(input logic [15:0] a, input logic d,
                        input logic rd, input logic wr,
                        input logic [7:0] wd);
    @(posedge clk_i);
    req_o <= '{addr: a, direct: d, rd: rd, wr: wr, wdata: wd};
    @(posedge clk_i);
    // Released: strobes drop, address and data flip
    req_o <= '{addr: ~a, direct: d, rd: 1'b0, wr: 1'b0, wdata: ~wd};
  endtask : access

  // Bank pointer write, then one edge for the mirror
  task automatic set_bank(input logic [2:0] n);
    @(posedge clk_i);
    bank_wr_o    <= 1'b1;
    bank_wdata_o <= n;
    @(posedge clk_i);
    bank_wr_o    <= 1'b0;
    bank_wdata_o <= ~n;
    @(posedge clk_i);
  endtask : set_bank
endmodule : cpu_model

// *** tb_top.sv ***
// Purpose: Self-checking bench for the memory map decoder.
// Assumes: Outputs are checked one cycle after each request.
// Notes:   A small-RAM instance shares the inputs for bank limits.
`timescale 1ns/1ns
module tb_top;
  import memmap_pkg::*;
  // Clock, reset and counters
  logic        clk_i      = 1'b0;
  logic        arst_n_i   = 1'b0;
  int          err_total  = 0;
  int          num_checks = 0;
  int          cycles     = 0;
  // Design connections
  cpu_req_t    req;
  target_sel_t sel;
  flash_area_t fa;
  logic        gpr, oob, oob_s, rvalid, bank_wr;
  logic [15:0] phys;
  logic [7:0]  rdata, osc, sysclk, stby;
  logic [2:0]  bank_wdata, bank;
  // Assigned registers and unassigned holes
  localparam logic [6:0] OFS [22] = '{7'h00, 7'h01, 7'h02, 7'h03,
    7'h05, 7'h07, 7'h08, 7'h0A, 7'h0B, 7'h0E, 7'h12, 7'h13, 7'h16,
    7'h17, 7'h18, 7'h19, 7'h28, 7'h29, 7'h2A, 7'h2B, 7'h2C, 7'h2D};
  localparam logic [6:0] UNA [5] = '{7'h04, 7'h0F, 7'h11, 7'h2E, 7'h7F};
  // Region edges and {io,xio,ram,flash,vector,nv,gpr}
  localparam logic [15:0] DEC_A [15] = '{16'h0000, 16'h007F, 16'h0080,
    16'h0100, 16'h01FF, 16'h0200, 16'h0F7F, 16'h0F80, 16'h0FFF,
    16'h1000, 16'hFFBA, 16'hFFBB, 16'hFFBF, 16'hFFC0, 16'hFFFF};
  localparam logic [6:0] DEC_E [15] = '{7'h40, 7'h40, 7'h10, 7'h11,
    7'h11, 7'h10, 7'h10, 7'h20, 7'h20, 7'h08, 7'h08, 7'h0A, 7'h0A,
    7'h0C, 7'h0C};
  localparam logic [7:0] OPS [4] = '{8'h10, 8'h8F, 8'h90, 8'hFF};

  always #25 clk_i = ~clk_i;

  cpu_model cpu_model_i (.clk_i(clk_i), .req_o(req), .bank_wr_o(bank_wr),
    .bank_wdata_o(bank_wdata));

  memory_map_decoder memory_map_decoder_i (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .req_i(req), .sel_o(sel), .flash_area_o(fa),
    .gpr_area_o(gpr), .bank_oob_o(oob), .phys_addr_o(phys),
    .rdata_o(rdata), .rvalid_o(rvalid), .bank_wr_i(bank_wr),
    .bank_wdata_i(bank_wdata), .bank_o(bank), .osc_wait_o(osc),
    .sysclk_ctrl_o(sysclk), .standby_ctrl_o(stby));

  // Smaller RAM variant, only its bound flag is watched
  memory_map_decoder #(.SMALL_RAM(1'b1)) memory_map_decoder_s_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req), .sel_o(),
    .flash_area_o(), .gpr_area_o(), .bank_oob_o(oob_s), .phys_addr_o(),
    .rdata_o(), .rvalid_o(), .bank_wr_i(bank_wr),
    .bank_wdata_i(bank_wdata), .bank_o(), .osc_wait_o(),
    .sysclk_ctrl_o(), .standby_ctrl_o());

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One request, then wait until its answer has settled
  task automatic op(input logic [15:0] a, input logic d, input logic rd,
                    input logic wr, input logic [7:0] wd);
    cpu_model_i.access(a, d, rd, wr, wd);
    @(negedge clk_i);
  endtask : op

  // Reset value of an assigned register
  function automatic logic [7:0] rst_val(input logic [6:0] o);
    if (o == 7'h05) return 8'hFF;
    if (o == 7'h07) return 8'h1B;
    return 8'h00;
  endfunction : rst_val

  // Closing report
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    logic [15:0] exp;
    repeat (3) @(posedge clk_i);
    check(16'(osc), 16'h00FF);
    check(16'(sysclk), 16'h001B);
    check(16'(bank), 16'h0000);
    arst_n_i <= 1'b1;
    foreach (OFS[i]) begin
      op({9'h000, OFS[i]}, 1'b0, 1'b1, 1'b0, 8'h00);
      check(16'({rvalid, rdata}), 16'({1'b1, rst_val(OFS[i])}));
    end
    $display("test register reset values done");
    foreach (OFS[i]) op({9'h000, OFS[i]}, 1'b0, 1'b0, 1'b1,
                        8'hA5 ^ {1'b0, OFS[i]});
    foreach (OFS[i]) begin
      op({9'h000, OFS[i]}, 1'b0, 1'b1, 1'b0, 8'h00);
      check(16'(rdata), 16'(8'hA5 ^ {1'b0, OFS[i]}));
    end
    check(16'(osc), 16'h00A0);
    check(16'(sysclk), 16'h00A2);
    check(16'(stby), 16'h00AD);
    $display("test register write and read back done");
    foreach (UNA[i]) begin
      op({9'h000, UNA[i]}, 1'b0, 1'b0, 1'b1, 8'hFF);
      op({9'h000, UNA[i]}, 1'b0, 1'b1, 1'b0, 8'h00);
      check(16'({rvalid, rdata}), 16'h0000);
    end
    op(16'h0005, 1'b0, 1'b1, 1'b0, 8'h00);
    check(16'(rdata), 16'h00A0);
    $display("test unassigned offsets done");
    foreach (DEC_A[i]) begin
      op(DEC_A[i], 1'b0, 1'b1, 1'b0, 8'h00);
      check(16'({sel, fa, gpr}), 16'(DEC_E[i]));
      check(phys, DEC_A[i]);
    end
    $display("test region decode done");
    for (int n = 0; n < 8; n++) begin
      cpu_model_i.set_bank(3'(n));
      @(negedge clk_i);
      check(16'(bank), 16'(n));
      foreach (OPS[k]) begin
        if (n == 0 && OPS[k] == 8'h8F) continue;
        exp = (OPS[k] < 8'h80) ? 16'(OPS[k])
            : 16'(OPS[k]) + 16'(n) * 16'h0080;
        op({8'h00, OPS[k]}, 1'b1, 1'b1, 1'b0, 8'h00);
        check(phys, exp);
        check(16'({sel, oob, oob_s}),
              16'({(OPS[k] < 8'h80) ? 4'h8 : 4'h2, 1'b0,
                   exp > 16'h028F}));
      end
    end
    $display("test direct bank mapping done");
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(negedge clk_i);
    check(16'({bank, osc}), 16'h00FF);
    op(16'h0000, 1'b0, 1'b1, 1'b0, 8'h00);
    check(16'({rvalid, rdata}), 16'h0100);
    $display("test second reset done");
    end_of_test();
  end
endmodule : tb_top
